// >>> common/usc_defs.vh
// register map, field positions, reset values and timing counts
`ifndef USC_DEFS_VH
`define USC_DEFS_VH
`define USC_ADDR_W        4
`define USC_A_CONTROL_ONE 4'h0
`define USC_A_CONTROL_TRE 4'h1
`define USC_A_BAUD_DIV    4'h2
`define USC_A_GUARD       4'h3
`define USC_A_DATA        4'h4
`define USC_A_STATUS_ONE  4'h5
`define USC_A_CARD_IRQ    4'h6
`define USC_A_CWT_LIMIT   4'h7
`define USC_A_IRQ_STAT    4'h8
`define USC_A_IRQ_MASK    4'h9
// control_one fields
`define USC_C1_TX_EN      0
`define USC_C1_RX_EN      1
`define USC_C1_SW_MODE    2
`define USC_C1_CARD       3
`define USC_C1_T1         4
`define USC_C1_BREAK      5
`define USC_C1_PREAMBLE   6
// control_three fields
`define USC_C3_SW_DIR     0
// status_one fields
`define USC_S1_TX_BUFFER_EMPTY_FLAG       0
`define USC_S1_TC         1
`define USC_S1_RDRF       2
`define USC_S1_FE         3
`define USC_S1_NF         4
`define USC_S1_PE         5
// card_interrupt_status fields
`define USC_CI_TXT        0
`define USC_CI_CWT        1
// interrupt status / mask fields
`define USC_IRQ_W         7
`define USC_IRQ_TC        0
`define USC_IRQ_RDRF      1
`define USC_IRQ_FE        2
`define USC_IRQ_NF        3
`define USC_IRQ_PE        4
`define USC_IRQ_TXT       5
`define USC_IRQ_CWT       6
// reset values and counts
`define USC_DIV_RST       16'h0010
`define USC_GUARD_RST     8'h02
`define USC_CWT_RST       16'h000C
`define USC_NACK_LIMIT    3'h3
`define USC_FRAME_LAST    4'hA
`define USC_PREAMBLE_PAT  11'h7FF
`define USC_BREAK_PAT     11'h000
`endif

// >>> src/usc_rx.v
// receive shifter: start detect, mid-bit sampling, error checks
`include "usc_defs.vh"
module usc_rx (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // control
  input  wire        en_i,
  input  wire [15:0] div_i,
  input  wire        line_i,
  // character out
  output reg         start_o,
  output reg         valid_o,
  output reg  [7:0]  data_o,
  output reg         fe_o,
  output reg         pe_o,
  output reg         nf_o
);
  reg        line_q;
  reg        busy_reg;
  reg [15:0] cnt_reg;
  reg [3:0]  idx_reg;
  reg [8:0]  sh_reg;
  reg        early_reg;
  reg        noise_reg;

  always @(posedge clk_i) begin
    if (rst_i) begin
      line_q    <= 1'b1;
      busy_reg  <= 1'b0;
      cnt_reg   <= 16'h0000;
      idx_reg   <= 4'h0;
      sh_reg    <= 9'h000;
      early_reg <= 1'b1;
      noise_reg <= 1'b0;
      start_o   <= 1'b0;
      valid_o   <= 1'b0;
      data_o    <= 8'h00;
      fe_o      <= 1'b0;
      pe_o      <= 1'b0;
      nf_o      <= 1'b0;
    end else begin
      line_q  <= line_i;
      start_o <= 1'b0;
      valid_o <= 1'b0;
      if (!en_i) begin
        busy_reg <= 1'b0;
      end else if (!busy_reg) begin
        if (line_q && !line_i) begin
          busy_reg  <= 1'b1;
          start_o   <= 1'b1;
          cnt_reg   <= {1'b0, div_i[15:1]};
          idx_reg   <= 4'h0;
          noise_reg <= 1'b0;
        end
      end else if (cnt_reg == 16'h0001) begin
        early_reg <= line_i;
        cnt_reg   <= 16'h0000;
      end else if (cnt_reg == 16'h0000) begin
        cnt_reg <= div_i - 16'h0001;
        idx_reg <= idx_reg + 4'h1;
        if (early_reg != line_i)
          noise_reg <= 1'b1;
        if (idx_reg == 4'h0 && line_i) begin
          busy_reg <= 1'b0;
        end else if (idx_reg == `USC_FRAME_LAST) begin
          busy_reg <= 1'b0;
          valid_o  <= 1'b1;
          data_o   <= sh_reg[7:0];
          pe_o     <= ^sh_reg;
          fe_o     <= ~line_i;
          nf_o     <= noise_reg | (early_reg != line_i);
        end else if (idx_reg != 4'h0) begin
          sh_reg <= {line_i, sh_reg[8:1]};
        end
      end else begin
        cnt_reg <= cnt_reg - 16'h0001;
      end
    end
  end
endmodule // usc_rx

// >>> src/usc_tx.v
// transmit holding buffer, shifter, guard time and nack detection
`include "usc_defs.vh"
module usc_tx (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // control
  input  wire        en_i,
  input  wire        etu_i,
  input  wire        drive_i,
  input  wire        card_t0_i,
  input  wire [7:0]  guard_i,
  // queue
  input  wire        load_i,
  input  wire [7:0]  data_i,
  input  wire        brk_i,
  input  wire        pre_i,
  // line
  input  wire        line_i,
  output reg         line_o,
  output reg         oe_n_o,
  // status
  output wire        tx_buffer_empty_flag_o,
  output reg         done_o,
  output reg         nack_o,
  output reg         txt_o
);
  localparam ST_IDLE  = 2'b00;
  localparam ST_SHIFT = 2'b01;
  localparam ST_GUARD = 2'b10;
  reg [1:0]  state_reg;
  reg [10:0] hold_reg;
  reg        hold_full;
  reg [10:0] sh_reg;
  reg [3:0]  bit_reg;
  reg [7:0]  gcnt_reg;
  reg [2:0]  nack_cnt;

  // with the line not driven, tx_buffer_empty_flag waits for the shift and the guard time to finish
  assign tx_buffer_empty_flag_o = !hold_full && (drive_i || state_reg == ST_IDLE);

  always @(posedge clk_i) begin
    if (rst_i || !en_i) begin
      state_reg <= ST_IDLE;
      hold_full <= 1'b0;
      hold_reg  <= `USC_PREAMBLE_PAT;
      sh_reg    <= `USC_PREAMBLE_PAT;
      bit_reg   <= 4'h0;
      gcnt_reg  <= 8'h00;
      nack_cnt  <= 3'h0;
      line_o    <= 1'b1;
      oe_n_o    <= 1'b1;
      done_o    <= 1'b0;
      nack_o    <= 1'b0;
      txt_o     <= 1'b0;
    end else begin
      done_o <= 1'b0;
      nack_o <= 1'b0;
      txt_o  <= 1'b0;
      if (load_i)
        hold_reg <= {1'b1, ^data_i, data_i, 1'b0};
      else if (brk_i)
        hold_reg <= `USC_BREAK_PAT;
      else if (pre_i)
        hold_reg <= `USC_PREAMBLE_PAT;
      if (load_i || brk_i || pre_i)
        hold_full <= 1'b1;
      case (state_reg)
        ST_IDLE: begin
          if (hold_full && etu_i) begin
            sh_reg    <= hold_reg;
            hold_full <= load_i | brk_i | pre_i;
            bit_reg   <= 4'h0;
            state_reg <= ST_SHIFT;
            line_o    <= hold_reg[0];
            oe_n_o    <= ~drive_i;
          end
        end
        ST_SHIFT: begin
          if (etu_i) begin
            if (bit_reg == `USC_FRAME_LAST) begin
              oe_n_o    <= 1'b1;
              line_o    <= 1'b1;
              gcnt_reg  <= guard_i;
              state_reg <= ST_GUARD;
              if (card_t0_i && !line_i) begin
                nack_o   <= 1'b1;
                nack_cnt <= nack_cnt + 3'h1;
                if (nack_cnt + 3'h1 == `USC_NACK_LIMIT)
                  txt_o <= 1'b1;
              end
            end else begin
              bit_reg <= bit_reg + 4'h1;
              sh_reg  <= {1'b1, sh_reg[10:1]};
              line_o  <= sh_reg[1];
            end
          end
        end
        ST_GUARD: begin
          if (gcnt_reg == 8'h00) begin
            state_reg <= ST_IDLE;
            done_o    <= ~hold_full;
          end else if (etu_i) begin
            gcnt_reg <= gcnt_reg - 8'h01;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule // usc_tx

// >>> src/usc_top.v
// serial port top: registers, status flags, card timers, interrupt
// How it works
// - in single-wire receive, queued data shifts undriven; tx_buffer_empty_flag sets when done
// - in T=0 card mode, tx complete sets on nack, before guard time
// - turning the transmitter off clears its nack counter
// - while framing error is set, received characters are thrown away
// - thrown away characters may still set noise and parity error flags
// - the framing error clear sequence also clears noise and parity flags
// - tx complete clears on status read then data write, preamble or break
// - after preamble or break clear, next clear needs no status read
// - in T=1, char wait timer stays off from tx block to rx block
// - writing 1 reloads the card timer, then its expiry flag drops
//
// Strobed register access and the register offsets were chosen for this implementation.
`include "usc_defs.vh"
module usc_top (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // register port
  input  wire [3:0]  addr_i,
  input  wire [15:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [15:0] rdata_o,
  // serial pins
  input  wire        rxd_i,
  input  wire        line_i,
  output wire        line_o,
  output wire        line_oe_n_o,
  // interrupt
  output reg         irq_o
);
  reg  [6:0]  ctrl_reg;
  reg         dir_reg;
  reg  [15:0] div_reg;
  reg  [7:0]  guard_reg;
  reg  [15:0] cwt_lim_reg;
  reg  [6:0]  imask_reg;
  reg  [6:0]  istat_reg;
  reg  [15:0] etu_cnt;
  reg         etu_reg;
  reg  [7:0]  rbuf_reg;
  reg         rdrf_reg;
  reg         fe_reg;
  reg         nf_reg;
  reg         pe_reg;
  reg         err_arm_reg;
  reg         tc_reg;
  reg         tc_arm_reg;
  reg         tc_loose_reg;
  reg         txt_reg;
  reg         cwt_reg;
  reg         cwt_run_reg;
  reg         cwt_rld_reg;
  reg  [15:0] cwt_cnt;

  wire        tx_buffer_empty_flag;
  wire        tx_done;
  wire        tx_nack;
  wire        tx_txt;
  wire        rx_start;
  wire        rx_valid;
  wire [7:0]  rx_data;
  wire        rx_fe;
  wire        rx_pe;
  wire        rx_nf;

  // register strobes
  wire wr_data  = wr_i && addr_i == `USC_A_DATA;
  wire wr_ctrl  = wr_i && addr_i == `USC_A_CONTROL_ONE;
  wire rd_stat  = rd_i && addr_i == `USC_A_STATUS_ONE;
  wire rd_data  = rd_i && addr_i == `USC_A_DATA;
  wire wr_card  = wr_i && addr_i == `USC_A_CARD_IRQ;
  wire q_brk    = wr_ctrl && wdata_i[`USC_C1_BREAK];
  wire q_pre    = wr_ctrl && wdata_i[`USC_C1_PREAMBLE];
  wire tx_en    = ctrl_reg[`USC_C1_TX_EN];
  wire rx_en    = ctrl_reg[`USC_C1_RX_EN];
  wire sw_mode  = ctrl_reg[`USC_C1_SW_MODE];
  wire card     = ctrl_reg[`USC_C1_CARD];
  wire t1       = ctrl_reg[`USC_C1_T1];
  wire drive    = !sw_mode || dir_reg;
  wire rx_line  = sw_mode ? line_i : rxd_i;

  // events raising interrupt status bits
  wire ev_tc    = tx_done || (tx_nack && card && !t1);
  wire ev_rdrf  = rx_valid && !fe_reg;
  wire ev_fe    = rx_valid && !fe_reg && rx_fe;
  wire ev_nf    = rx_valid && rx_nf;
  wire ev_pe    = rx_valid && rx_pe;
  wire cwt_hit  = cwt_run_reg && !cwt_reg && cwt_cnt == cwt_lim_reg;
  wire [6:0] ev = {cwt_hit, tx_txt, ev_pe, ev_nf, ev_fe, ev_rdrf, ev_tc};

  // tx complete clear actions
  wire tc_act   = wr_data || q_brk || q_pre;
  wire tc_clr   = tc_reg && tc_act && (tc_arm_reg || tc_loose_reg);
  // framing error clear sequence: status read then data read
  wire err_clr  = err_arm_reg && rd_data;

  // set wins over clear for every flag
  function flag_upd;
    input cur;
    input set;
    input clr;
    begin
      flag_upd = set | (cur & ~clr);
    end
  endfunction

  usc_tx u_tx (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .en_i      (tx_en),
    .etu_i     (etu_reg),
    .drive_i   (drive),
    .card_t0_i (card && !t1),
    .guard_i   (guard_reg),
    .load_i    (wr_data),
    .data_i    (wdata_i[7:0]),
    .brk_i     (q_brk),
    .pre_i     (q_pre),
    .line_i    (rx_line),
    .line_o    (line_o),
    .oe_n_o    (line_oe_n_o),
    .tx_buffer_empty_flag_o    (tx_buffer_empty_flag),
    .done_o    (tx_done),
    .nack_o    (tx_nack),
    .txt_o     (tx_txt)
  );

  usc_rx u_rx (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .en_i    (rx_en),
    .div_i   (div_reg),
    .line_i  (rx_line),
    .start_o (rx_start),
    .valid_o (rx_valid),
    .data_o  (rx_data),
    .fe_o    (rx_fe),
    .pe_o    (rx_pe),
    .nf_o    (rx_nf)
  );

  // control registers
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg    <= 7'h00;
      dir_reg     <= 1'b0;
      div_reg     <= `USC_DIV_RST;
      guard_reg   <= `USC_GUARD_RST;
      cwt_lim_reg <= `USC_CWT_RST;
      imask_reg   <= 7'h00;
    end else if (wr_i) begin
      case (addr_i)
        `USC_A_CONTROL_ONE: ctrl_reg    <= {2'b00, wdata_i[4:0]};
        `USC_A_CONTROL_TRE: dir_reg     <= wdata_i[`USC_C3_SW_DIR];
        `USC_A_BAUD_DIV:    div_reg     <= wdata_i;
        `USC_A_GUARD:       guard_reg   <= wdata_i[7:0];
        `USC_A_CWT_LIMIT:   cwt_lim_reg <= wdata_i;
        `USC_A_IRQ_MASK:    imask_reg   <= wdata_i[6:0];
        default:            ctrl_reg    <= ctrl_reg;
      endcase
    end
  end

  // bit-time enable divider
  always @(posedge clk_i) begin
    if (rst_i) begin
      etu_cnt <= 16'h0000;
      etu_reg <= 1'b0;
    end else begin
      etu_reg <= (etu_cnt == 16'h0000);
      if (etu_cnt == 16'h0000)
        etu_cnt <= div_reg - 16'h0001;
      else
        etu_cnt <= etu_cnt - 16'h0001;
    end
  end

  // receive buffer and error flags
  always @(posedge clk_i) begin
    if (rst_i) begin
      rbuf_reg    <= 8'h00;
      rdrf_reg    <= 1'b0;
      fe_reg      <= 1'b0;
      nf_reg      <= 1'b0;
      pe_reg      <= 1'b0;
      err_arm_reg <= 1'b0;
    end else begin
      if (ev_rdrf)
        rbuf_reg <= rx_data;
      rdrf_reg <= flag_upd(rdrf_reg, ev_rdrf, rd_data);
      fe_reg   <= flag_upd(fe_reg, ev_fe, err_clr);
      nf_reg   <= flag_upd(nf_reg, ev_nf, err_clr);
      pe_reg   <= flag_upd(pe_reg, ev_pe, err_clr);
      if (rd_stat)
        err_arm_reg <= fe_reg | nf_reg | pe_reg;
      else if (rd_data)
        err_arm_reg <= 1'b0;
    end
  end

  // transmit complete flag and its clearing sequence
  always @(posedge clk_i) begin
    if (rst_i) begin
      tc_reg       <= 1'b0;
      tc_arm_reg   <= 1'b0;
      tc_loose_reg <= 1'b0;
    end else begin
      tc_reg <= flag_upd(tc_reg, ev_tc, tc_clr);
      if (tc_clr || ev_tc)
        tc_arm_reg <= 1'b0;
      else if (rd_stat && tc_reg)
        tc_arm_reg <= 1'b1;
      if (tc_clr)
        tc_loose_reg <= (q_brk || q_pre) && !wr_data;
    end
  end

  // card flags and char wait timer
  always @(posedge clk_i) begin
    if (rst_i) begin
      txt_reg     <= 1'b0;
      cwt_reg     <= 1'b0;
      cwt_run_reg <= 1'b0;
      cwt_rld_reg <= 1'b0;
      cwt_cnt     <= 16'h0000;
    end else begin
      txt_reg <= flag_upd(txt_reg, tx_txt,
                          wr_card && wdata_i[`USC_CI_TXT]);
      cwt_rld_reg <= wr_card && wdata_i[`USC_CI_CWT];
      cwt_reg <= flag_upd(cwt_reg, cwt_hit,
                          cwt_rld_reg && cwt_cnt == 16'h0000);
      if (!card || !t1 || tx_done || wr_data)
        cwt_run_reg <= 1'b0;
      else if (rx_start)
        cwt_run_reg <= 1'b1;
      if (rx_start || !cwt_run_reg || (wr_card && wdata_i[`USC_CI_CWT]))
        cwt_cnt <= 16'h0000;
      else if (etu_reg && !cwt_hit && !cwt_reg)
        cwt_cnt <= cwt_cnt + 16'h0001;
    end
  end

  // interrupt status, write one to clear
  always @(posedge clk_i) begin
    if (rst_i) begin
      istat_reg <= 7'h00;
      irq_o     <= 1'b0;
    end else begin
      if (wr_i && addr_i == `USC_A_IRQ_STAT)
        istat_reg <= ev | (istat_reg & ~wdata_i[6:0]);
      else
        istat_reg <= ev | istat_reg;
      irq_o <= |(istat_reg & imask_reg);
    end
  end

  // read data, one cycle after the strobe
  always @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= 16'h0000;
    end else if (rd_i) begin
      case (addr_i)
        `USC_A_CONTROL_ONE: rdata_o <= {9'h000, ctrl_reg};
        `USC_A_CONTROL_TRE: rdata_o <= {15'h0000, dir_reg};
        `USC_A_BAUD_DIV:    rdata_o <= div_reg;
        `USC_A_GUARD:       rdata_o <= {8'h00, guard_reg};
        `USC_A_DATA:        rdata_o <= {8'h00, rbuf_reg};
        `USC_A_STATUS_ONE:  rdata_o <= {10'h000, pe_reg, nf_reg, fe_reg,
                                        rdrf_reg, tc_reg, tx_buffer_empty_flag};
        `USC_A_CARD_IRQ:    rdata_o <= {14'h0000, cwt_reg, txt_reg};
        `USC_A_CWT_LIMIT:   rdata_o <= cwt_lim_reg;
        `USC_A_IRQ_STAT:    rdata_o <= {9'h000, istat_reg};
        `USC_A_IRQ_MASK:    rdata_o <= {9'h000, imask_reg};
        default:            rdata_o <= 16'h0000;
      endcase
    end else begin
      rdata_o <= 16'h0000;
    end
  end
endmodule // usc_top

// >>> verif/usc_top_properties.sv
// checker: port-level properties of the serial port top
module usc_top_properties (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // register port
  input wire logic [3:0]  addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [15:0] rdata_o,
  // pins and interrupt
  input wire logic        rxd_i,
  input wire logic        line_i,
  input wire logic        line_o,
  input wire logic        line_oe_n_o,
  input wire logic        irq_o
);
  logic        sw_reg;
  logic        dir_reg;
  logic [15:0] div_reg;
  logic [6:0]  mask_reg;
  int          low_reg;
  wire         sw_rx = sw_reg & ~dir_reg;
  // shadow of mode, divider and mask; count of driven cycles
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sw_reg   <= 1'b0;
      dir_reg  <= 1'b0;
      div_reg  <= 16'h0010;
      mask_reg <= 7'h00;
      low_reg  <= 0;
    end else begin
      if (wr_i && addr_i == 4'h0) sw_reg <= wdata_i[2];
      if (wr_i && addr_i == 4'h1) dir_reg <= wdata_i[0];
      if (wr_i && addr_i == 4'h2) div_reg <= wdata_i;
      if (wr_i && addr_i == 4'h9) mask_reg <= wdata_i[6:0];
      low_reg <= line_oe_n_o ? 0 : low_reg + 1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_rdata_quiet;
    !$past(rd_i) |-> rdata_o == 16'h0000;
  endproperty
  a_rdata_quiet: assert property (p_rdata_quiet) else $error("read data outside answer cycle");
  property p_reset_quiet;
    $past(rst_i) |-> line_oe_n_o && line_o && !irq_o;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("pins active after reset");
  property p_sw_rx_quiet;
    sw_rx [*3] |-> line_oe_n_o;
  endproperty
  a_sw_rx_quiet: assert property (p_sw_rx_quiet) else $error("pin driven in receive direction");
  property p_start_low;
    $fell(line_oe_n_o) && !line_o |-> (!line_o && !line_oe_n_o) [*4];
  endproperty
  a_start_low: assert property (p_start_low) else $error("start bit wrong");
  property p_frame_len;
    $rose(line_oe_n_o) |-> low_reg == 11 * int'(div_reg);
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame length wrong");
  property p_bit_edge;
    !line_oe_n_o && !$past(line_oe_n_o) && line_o != $past(line_o)
      |-> (low_reg % int'(div_reg)) == 0;
  endproperty
  a_bit_edge: assert property (p_bit_edge) else $error("line changed inside a bit");
  property p_irq_off;
    mask_reg == 7'h00 && $past(mask_reg) == 7'h00 |-> !irq_o;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt with all masked");
  property p_irq_read;
    rd_i && addr_i == 4'h8 |=> irq_o == |(rdata_o[6:0] & mask_reg);
  endproperty
  a_irq_read: assert property (p_irq_read) else $error("interrupt not status and mask");
  c_frame: cover property ($rose(line_oe_n_o));
  c_irq: cover property ($rose(irq_o));
  c_sw_rx: cover property (sw_rx && wr_i && addr_i == 4'h4);
endmodule // usc_top_properties
bind usc_top usc_top_properties i_usc_top_properties (
  .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rxd_i(rxd_i),
  .line_i(line_i), .line_o(line_o), .line_oe_n_o(line_oe_n_o),
  .irq_o(irq_o));

// >>> verif/usc_card_model.sv
// partner model: card on the serial pin, frame capture, nack, rx source
module usc_card_model #(
  parameter int BIT = 4
) (
  input  wire logic       clk_i,
  input  wire logic       pin_i,
  input  wire logic       nack_i,
  output logic            pull_o,
  output logic            rxd_o,
  output logic [7:0]      byte_o,
  output logic            par_o,
  output int              frames_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    pull_o   = 1'b0;
    rxd_o    = 1'b1;
    byte_o   = 8'h00;
    par_o    = 1'b0;
    frames_o = 0;
  end
  // sample mid-bit; a nack pulls the pin low across the end of stop
  always begin
    @(negedge pin_i);
    repeat (BIT / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk_i);
      byte_o[i] = pin_i;
    end
    repeat (BIT) @(posedge clk_i);
    par_o = pin_i;
    repeat (BIT) @(posedge clk_i);
    frames_o++;
    if (nack_i) begin
      pull_o <= 1'b1;
      repeat (BIT) @(posedge clk_i);
      pull_o <= 1'b0;
    end
  end
  // send one frame on rxd: start, data lsb first, parity, stop
  task automatic send(input logic [7:0] d, input logic bad_par,
                      input logic stop);
    logic [10:0] bits;
    bits = {stop, ^d ^ bad_par, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxd_o <= bits[i];
      repeat (BIT) @(posedge clk_i);
    end
    rxd_o <= 1'b1;
  endtask
endmodule // usc_card_model

// >>> verif/usc_top_tb.sv
// testbench: registers, tx flags, card nack, single wire, rx errors
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module usc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic        we;
    logic [3:0]  a;
    logic [15:0] d;
    logic [15:0] e;
  } usc_row_t;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [3:0]  addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        nack = 1'b0;
  wire  [15:0] rdata_o;
  wire         rxd_i, line_i, line_o, line_oe_n_o, irq_o, pull, cpar;
  wire  [7:0]  cbyte;
  int          frames;
  int          f;
  int          n;
  logic [15:0] v;
  int          miscompares = 0;
  int          checks = 0;
  usc_row_t    rows [14] = '{
    '{1'b0, 4'h0, 16'h0000, 16'h0000}, '{1'b0, 4'h1, 16'h0000, 16'h0000},
    '{1'b0, 4'h2, 16'h0000, 16'h0010}, '{1'b0, 4'h3, 16'h0000, 16'h0002},
    '{1'b0, 4'h5, 16'h0000, 16'h0001}, '{1'b0, 4'h6, 16'h0000, 16'h0000},
    '{1'b0, 4'h7, 16'h0000, 16'h000C}, '{1'b0, 4'h8, 16'h0000, 16'h0000},
    '{1'b0, 4'h9, 16'h0000, 16'h0000}, '{1'b0, 4'hA, 16'h0000, 16'h0000},
    '{1'b1, 4'h2, 16'h0004, 16'h0004}, '{1'b1, 4'h3, 16'h0002, 16'h0002},
    '{1'b1, 4'h7, 16'h0008, 16'h0008}, '{1'b1, 4'hA, 16'hFFFF, 16'h0000}};
  // pin level: device drives when enabled, card may pull low, else high
  assign line_i = (line_oe_n_o ? 1'b1 : line_o) & ~pull;
  usc_top i_usc_top (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .rxd_i(rxd_i), .line_i(line_i), .line_o(line_o),
    .line_oe_n_o(line_oe_n_o), .irq_o(irq_o));
  usc_card_model #(.BIT(4)) i_usc_card_model (.clk_i(clk_i),
    .pin_i(line_i), .nack_i(nack), .pull_o(pull), .rxd_o(rxd_i),
    .byte_o(cbyte), .par_o(cpar), .frames_o(frames));
  always #20 clk_i = ~clk_i;
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic wait_irq();
    for (int i = 0; i < 3000 && irq_o !== 1'b1; i++) @(posedge clk_i);
    `CHK("irq", 1'b1, irq_o)
  endtask
  task automatic wait_oe();
    for (int i = 0; i < 3000 && line_oe_n_o !== 1'b0; i++) @(posedge clk_i);
    for (int i = 0; i < 3000 && line_oe_n_o !== 1'b1; i++) @(posedge clk_i);
    `CHK("frame_end", 1'b1, line_oe_n_o)
  endtask
  task automatic wait_frames(input int c);
    for (int i = 0; i < 3000 && frames <= c; i++) @(posedge clk_i);
  endtask
  task automatic finish_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #1600000;
    miscompares++;
    finish_test();
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].we) wr(rows[i].a, rows[i].d);
      rd(rows[i].a, v);
      `CHK("reg", rows[i].e, v)
    end
    $display("done: registers");
    wr(4'h9, 16'h0001);
    wr(4'h0, 16'h0001);
    wr(4'h4, 16'h00A5);
    wait_oe();
    rd(4'h5, v);
    `CHK("tc_guard", 1'b0, v[1])
    wait_irq();
    `CHK("byte", 8'hA5, cbyte)
    `CHK("par", 1'b0, cpar)
    wr(4'h4, 16'h003C);
    rd(4'h5, v);
    `CHK("tc_kept", 1'b1, v[1])
    wr(4'h8, 16'h0001);
    repeat (2) @(posedge clk_i);
    `CHK("irq_clr", 1'b0, irq_o)
    wr(4'h4, 16'h0081);
    rd(4'h5, v);
    `CHK("tc_clr", 1'b0, v[1])
    wait_irq();
    `CHK("byte", 8'h81, cbyte)
    $display("done: tx complete");
    wr(4'h8, 16'h0001);
    rd(4'h5, v);
    wr(4'h0, 16'h0021);
    rd(4'h5, v);
    `CHK("tc_brk", 1'b0, v[1])
    wait_irq();
    `CHK("byte", 8'h00, cbyte)
    wr(4'h8, 16'h0001);
    wr(4'h0, 16'h0041);
    rd(4'h5, v);
    `CHK("tc_pre", 1'b0, v[1])
    wr(4'h4, 16'h0055);
    wait_frames(frames);
    `CHK("byte", 8'h55, cbyte)
    wr(4'h8, 16'h0001);
    wait_irq();
    $display("done: break and preamble");
    wr(4'h3, 16'h000C);
    wr(4'h1, 16'h0001);
    wr(4'h0, 16'h000F);
    nack = 1'b1;
    for (int k = 0; k < 5; k++) begin
      if (k == 2) begin
        wr(4'h0, 16'h000E);
        wr(4'h0, 16'h000F);
      end
      rd(4'h5, v);
      wr(4'h4, 16'h00C3);
      wait_oe();
      repeat (2) @(posedge clk_i);
      rd(4'h5, v);
      `CHK("tc_nack", 1'b1, v[1])
      rd(4'h6, v);
      `CHK("txt", k == 4, v[0])
    end
    nack = 1'b0;
    wr(4'h6, 16'h0003);
    rd(4'h6, v);
    `CHK("card_w1c", 1'b0, v[0])
    $display("done: card nack");
    wr(4'h1, 16'h0000);
    wr(4'h0, 16'h0005);
    f = frames;
    wr(4'h4, 16'h0099);
    rd(4'h5, v);
    `CHK("tx_buffer_empty_flag_busy", 1'b0, v[0])
    for (n = 0; n < 200 && v[0] !== 1'b1; n++) rd(4'h5, v);
    `CHK("tx_buffer_empty_flag_set", 1'b1, v[0])
    `CHK("no_frame", f, frames)
    wr(4'h1, 16'h0001);
    wr(4'h4, 16'h0066);
    wait_frames(f);
    `CHK("byte", 8'h66, cbyte)
    $display("done: single wire");
    wr(4'h8, 16'h007F);
    wr(4'h9, 16'h0010);
    wr(4'h0, 16'h0003);
    rd(4'h5, v);
    rd(4'h4, v);
    i_usc_card_model.send(8'h11, 1'b0, 1'b0);
    repeat (4) @(posedge clk_i);
    rd(4'h4, v);
    i_usc_card_model.send(8'h3C, 1'b1, 1'b1);
    repeat (4) @(posedge clk_i);
    rd(4'h5, v);
    `CHK("rx_err", 4'b1010, v[5:2])
    `CHK("irq_pe", 1'b1, irq_o)
    rd(4'h4, v);
    rd(4'h5, v);
    `CHK("err_clr", 3'b000, v[5:3])
    i_usc_card_model.send(8'h5A, 1'b0, 1'b1);
    repeat (4) @(posedge clk_i);
    rd(4'h4, v);
    `CHK("rx_data", 16'h005A, v)
    $display("done: receive errors");
    wr(4'h0, 16'h001B);
    i_usc_card_model.send(8'h42, 1'b0, 1'b1);
    rd(4'h6, v);
    `CHK("cwt_set", 1'b1, v[1])
    wr(4'h6, 16'h0002);
    rd(4'h6, v);
    `CHK("cwt_clr", 1'b0, v[1])
    wr(4'h4, 16'h0077);
    repeat (100) @(posedge clk_i);
    rd(4'h6, v);
    `CHK("cwt_tx", 1'b0, v[1])
    $display("done: char wait");
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(4'h2, v);
    `CHK("rst_div", 16'h0010, v)
    rd(4'h5, v);
    `CHK("rst_stat", 16'h0001, v)
    $display("done: reset");
    finish_test();
  end
endmodule // usc_top_tb
